// [include/sfrs_defs.svh]
// Field positions, byte counts and sequence limits of the serial flash front end
`ifndef SFRS_DEFS_SVH
`define SFRS_DEFS_SVH

// Status word field positions
`define SFRS_STS_BUSY 0
`define SFRS_STS_LATCH 1
`define SFRS_STS_PROT_LSB 2
`define SFRS_STS_PROT_MSB 4
`define SFRS_STS_LOCK 7

// Reset values of the non-volatile status fields
`define SFRS_PROT_RESET 3'h0
`define SFRS_LOCK_RESET 1'b0

// Bit and byte counting within one chip-select frame
`define SFRS_BIT_FIRST 3'h0
`define SFRS_BIT_LAST 3'h7
`define SFRS_BYTE_MAX 3'h7
`define SFRS_CMD_BYTES 3'h1
`define SFRS_STSW_BYTES 3'h2
`define SFRS_ADDR_LAST_BYTE 3'h3
`define SFRS_HDR_BYTES 3'h4
`define SFRS_PROG_MIN_BYTES 3'h5

// Identity sequence positions
`define SFRS_ID_MAKER 2'h0
`define SFRS_ID_TYPE 2'h1
`define SFRS_ID_CAP 2'h2

// Host clock ceilings for the two array reads, in MHz
`define SFRS_NORM_READ_MAX_MHZ 33
`define SFRS_FAST_READ_MAX_MHZ 50

`endif

// [include/sfrs_pkg.sv]
// Types shared by the serial flash command front end
package sfrs_pkg;

    // What the serial output is carrying in the current frame
    typedef enum logic [1:0] {
        SFRS_TX_NONE,
        SFRS_TX_ARRAY,
        SFRS_TX_ID,
        SFRS_TX_STATUS
    } sfrs_tx_e;

    // Kind of write operation handed to the program/erase engine
    typedef enum logic [1:0] {
        SFRS_OP_PAGE,
        SFRS_OP_BLOCK,
        SFRS_OP_ARRAY
    } sfrs_op_e;

endpackage

// [design/sfrs_front.sv]
// Serial flash command front end: reads, identity, latch and status word
`include "sfrs_defs.svh"

// How it works
// RQ1: Normal read: command, 24-bit address, 33 MHz.
// RQ2: Fast read adds one dummy byte, 50 MHz.
// RQ3: Output bits change on falling clock edges.
// RQ4: Address advances by one per output byte.
// RQ5: Address wraps from top to zero.
// RQ6: Chip select high stops output anywhere.
// RQ7: Array reads refused while an operation runs.
// RQ8: Identity: maker byte, type, capacity bytes.
// RQ9: Identity query refused while an operation runs.
// RQ10: Latch-set command sets the write-permit latch.
// RQ11: Latch commands are exactly one byte framed.
// RQ12: Latch-clear resets latch; writes then refused.
// RQ13: Latch cleared at reset and completions.
// RQ14: Status query accepted at any time.
// RQ15: Status byte repeats while chip select low.
// RQ16: Host polls busy flag before new commands.
// RQ17: Status bit 0 is the busy flag.
// RQ18: Bit 1 is latch; zero refuses writes.
// RQ19: Status update never changes the latch; the code clears it on an accepted update.
// RQ20: Bits 4..2 protect an upper address range.
// RQ21: Whole-array wipe only with protect field zero.
// RQ22: Lock bit plus low protect pin freezes status.
// RQ23: Status bits 6 and 5 read zero.
// RQ24: Write-type commands need whole-byte frames.
// RQ25: Most significant bit first, first rise command.
// RQ26: Command codes are module parameters.
module sfrs_front
    import sfrs_pkg::*;
#(
    parameter int ADDR_W = 22,                    // Array address width
    parameter int SECT_W = 6,                     // Block index width (top address bits)
    parameter logic [7:0] NORM_READ_CMD = 8'h03,  // Command codes, see RQ26
    parameter logic [7:0] FAST_READ_CMD = 8'h0b,
    parameter logic [7:0] IDENTITY_QUERY = 8'h9f,
    parameter logic [7:0] LATCH_SET_CMD = 8'h06,
    parameter logic [7:0] LATCH_CLEAR_CMD = 8'h04,
    parameter logic [7:0] STATUS_QUERY = 8'h05,
    parameter logic [7:0] STATUS_UPDATE_CMD = 8'h01,
    parameter logic [7:0] PAGE_WRITE_CMD = 8'h02,
    parameter logic [7:0] BLOCK64K_WIPE_CMD = 8'hd8,
    parameter logic [7:0] ARRAY_WIPE_CMD = 8'hc7,
    parameter logic [7:0] MAKER_CODE = 8'h5a,     // Arbitrary value
    parameter logic [7:0] MEM_TYPE_CODE = 8'h3c,  // Arbitrary value
    parameter logic [7:0] CAPACITY_CODE = 8'h2d   // Arbitrary value
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so_r,
    output logic so_oe_n_r,
    input wire logic write_protect_n,
    output logic [ADDR_W-1:0] arr_addr_r,
    input wire logic [7:0] arr_data,
    input wire logic op_busy,
    input wire logic op_done,
    output logic op_start_r,
    output sfrs_op_e op_kind_r,
    output logic [ADDR_W-1:0] op_addr_r,
    output logic [7:0] status_word_r
);

    ////////////////////////////////////////////////////////////////////////////
    // Link side, clocked by the host serial clock

    logic frame_fresh_r;         // No edge seen yet in this frame
    logic [2:0] bits_r;          // Bits taken in the current byte
    logic [2:0] bytes_r;         // Whole bytes taken, saturating
    logic [7:0] shift_r;         // Incoming shift register
    logic [7:0] cmd_r;           // Command byte of the frame
    logic [23:0] addr_r;         // Address bytes of the frame
    logic [7:0] wdat_r;          // First byte after the command
    logic frame_tgl_r;           // Toggles once per clocked frame
    sfrs_tx_e tx_mode_r;         // Current output source
    sfrs_tx_e tx_mode_nxt;
    logic [7:0] out_byte_r;      // Byte for identity or status output
    logic [7:0] out_byte_nxt;
    logic [1:0] id_idx_r;        // Next identity byte to send
    logic [1:0] id_idx_nxt;
    logic [ADDR_W-1:0] arr_addr_nxt;
    logic [7:0] sts_m1_r;        // Status word synchroniser, first stage
    logic [7:0] sts_s_r;         // Status word synchroniser, second stage

    // Frame start is seen at the first rise; chip select high rearms it
    always_ff @(posedge sck or posedge cs_n or negedge nrst) begin
        if (!nrst) begin
            frame_fresh_r <= 1'b1;
        end else if (cs_n) begin
            frame_fresh_r <= 1'b1;
        end else begin
            frame_fresh_r <= 1'b0;
        end
    end

    // Counters restart on the first rise, so they hold after the frame ends
    wire [2:0] bit_idx = frame_fresh_r ? `SFRS_BIT_FIRST : bits_r;
    wire [2:0] byte_idx = frame_fresh_r ? 3'h0 : bytes_r;
    wire [7:0] rx_byte = {(frame_fresh_r ? 7'h00 : shift_r[6:0]), si};  // see RQ25
    wire byte_end = (bit_idx == `SFRS_BIT_LAST);
    wire [2:0] bits_nxt = bit_idx + 3'h1;
    wire [2:0] bytes_nxt = (byte_end && byte_idx != `SFRS_BYTE_MAX) ? byte_idx + 3'h1 : byte_idx;
    wire sck_busy = sts_s_r[`SFRS_STS_BUSY];
    wire sfrs_tx_e mode_cur = frame_fresh_r ? SFRS_TX_NONE : tx_mode_r;
    wire [23:0] addr_full = {addr_r[15:0], rx_byte};
    wire [7:0] id_byte = (id_idx_r == `SFRS_ID_MAKER) ? MAKER_CODE :
                         (id_idx_r == `SFRS_ID_TYPE) ? MEM_TYPE_CODE : CAPACITY_CODE;
    wire [7:0] tx_byte = (tx_mode_r == SFRS_TX_ARRAY) ? arr_data : out_byte_r;

    // Output source selection at byte boundaries
    always_comb begin
        tx_mode_nxt = mode_cur;
        out_byte_nxt = out_byte_r;
        id_idx_nxt = id_idx_r;
        arr_addr_nxt = arr_addr_r;
        if (byte_end && byte_idx == 3'h0) begin
            // Command byte just completed
            tx_mode_nxt = SFRS_TX_NONE;
            if (rx_byte == STATUS_QUERY) begin
                tx_mode_nxt = SFRS_TX_STATUS;                      // see RQ14
                out_byte_nxt = sts_s_r;
            end else if (rx_byte == IDENTITY_QUERY && !sck_busy) begin
                tx_mode_nxt = SFRS_TX_ID;                          // see RQ9
                out_byte_nxt = MAKER_CODE;                         // see RQ8
                id_idx_nxt = `SFRS_ID_TYPE;
            end
        end else if (byte_end) begin
            unique case (mode_cur)
                SFRS_TX_STATUS: begin
                    out_byte_nxt = sts_s_r;                        // see RQ15
                end
                SFRS_TX_ID: begin
                    out_byte_nxt = id_byte;                        // see RQ8
                    id_idx_nxt = (id_idx_r == `SFRS_ID_CAP) ? `SFRS_ID_MAKER : id_idx_r + 2'h1;
                end
                SFRS_TX_ARRAY: begin
                    arr_addr_nxt = arr_addr_r + 1'b1;              // see RQ4, RQ5
                end
                SFRS_TX_NONE: begin
                    // Address complete: normal read starts now, fast read after a dummy byte
                    if (byte_idx == `SFRS_ADDR_LAST_BYTE && !sck_busy &&
                        (cmd_r == NORM_READ_CMD || cmd_r == FAST_READ_CMD)) begin  // see RQ7
                        arr_addr_nxt = addr_full[ADDR_W-1:0];
                        if (cmd_r == NORM_READ_CMD) begin
                            tx_mode_nxt = SFRS_TX_ARRAY;           // see RQ1
                        end
                    end else if (byte_idx == `SFRS_HDR_BYTES && !sck_busy && cmd_r == FAST_READ_CMD) begin
                        tx_mode_nxt = SFRS_TX_ARRAY;               // see RQ2
                    end
                end
            endcase
        end
    end

    // Input shifting and frame capture on rising edges
    always_ff @(posedge sck or negedge nrst) begin
        if (!nrst) begin
            bits_r <= 3'h0;
            bytes_r <= 3'h0;
            shift_r <= 8'h00;
            frame_tgl_r <= 1'b0;
        end else begin
            bits_r <= bits_nxt;
            bytes_r <= bytes_nxt;
            shift_r <= rx_byte;                                    // see RQ25
            frame_tgl_r <= frame_tgl_r ^ frame_fresh_r;
        end
    end

    // Command, address and data bytes held for the system side
    always_ff @(posedge sck or negedge nrst) begin
        if (!nrst) begin
            cmd_r <= 8'h00;
            addr_r <= 24'h000000;
            wdat_r <= 8'h00;
        end else if (byte_end) begin
            if (byte_idx == 3'h0) begin
                cmd_r <= rx_byte;
            end
            if (byte_idx != 3'h0 && byte_idx <= `SFRS_ADDR_LAST_BYTE) begin
                addr_r <= addr_full;
            end
            if (byte_idx == 3'h1) begin
                wdat_r <= rx_byte;
            end
        end
    end

    // Output source state
    always_ff @(posedge sck or negedge nrst) begin
        if (!nrst) begin
            tx_mode_r <= SFRS_TX_NONE;
            out_byte_r <= 8'h00;
            id_idx_r <= `SFRS_ID_MAKER;
            arr_addr_r <= '0;
        end else begin
            tx_mode_r <= tx_mode_nxt;
            out_byte_r <= out_byte_nxt;
            id_idx_r <= id_idx_nxt;
            arr_addr_r <= arr_addr_nxt;
        end
    end

    // Status word into the link domain; fields change rarely, so tearing is benign
    always_ff @(posedge sck or negedge nrst) begin
        if (!nrst) begin
            sts_m1_r <= 8'h00;
            sts_s_r <= 8'h00;
        end else begin
            sts_m1_r <= status_word_r;
            sts_s_r <= sts_m1_r;
        end
    end

    // Serial output changes on the falling edge, MSB first
    always_ff @(negedge sck or negedge nrst) begin
        if (!nrst) begin
            so_r <= 1'b0;
        end else begin
            so_r <= tx_byte[~bits_r];                              // see RQ3
        end
    end

    // Driver released as soon as chip select rises
    always_ff @(negedge sck or posedge cs_n or negedge nrst) begin
        if (!nrst) begin
            so_oe_n_r <= 1'b1;
        end else if (cs_n) begin
            so_oe_n_r <= 1'b1;                                     // see RQ6
        end else begin
            so_oe_n_r <= (tx_mode_r == SFRS_TX_NONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System side: frame end handling and status word

    logic cs_m1_r, cs_s_r, cs_d_r;       // Chip select synchroniser and delay
    logic wp_m1_r, wp_s_r;               // Protect pin synchroniser
    logic tg_m1_r, tg_s_r, tg_seen_r;    // Frame toggle synchroniser
    logic latch_r;                       // Write-permit latch
    logic [2:0] prot_r;                  // Protect-size field, non-volatile
    logic lock_r;                        // Status lock bit, non-volatile
    logic latch_nxt;

    // Two-flop synchronisers for pins and the frame event
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cs_m1_r <= 1'b1;
            cs_s_r <= 1'b1;
            cs_d_r <= 1'b1;
            wp_m1_r <= 1'b1;
            wp_s_r <= 1'b1;
            tg_m1_r <= 1'b0;
            tg_s_r <= 1'b0;
        end else begin
            cs_m1_r <= cs_n;
            cs_s_r <= cs_m1_r;
            cs_d_r <= cs_s_r;
            wp_m1_r <= write_protect_n;
            wp_s_r <= wp_m1_r;
            tg_m1_r <= frame_tgl_r;
            tg_s_r <= tg_m1_r;
        end
    end

    // Frame info is stable here: the host clock is idle once chip select is high
    wire frame_end = cs_s_r && !cs_d_r && (tg_s_r != tg_seen_r);
    wire whole = frame_end && (bits_r == `SFRS_BIT_FIRST);                       // see RQ24
    wire hw_lock = lock_r && !wp_s_r;                                            // see RQ22
    wire write_ok = latch_r && !op_busy;                                         // see RQ18
    wire [SECT_W:0] prot_span = (SECT_W + 1)'(1) << (prot_r - 3'h1);
    wire [SECT_W:0] prot_sum = {1'b0, addr_r[ADDR_W-1 -: SECT_W]} + prot_span;
    wire in_prot = (prot_r == 3'h7) || (prot_r != 3'h0 && prot_sum[SECT_W]);  // see RQ20
    wire set_ev = whole && cmd_r == LATCH_SET_CMD && bytes_r == `SFRS_CMD_BYTES;      // see RQ11
    wire clr_ev = whole && cmd_r == LATCH_CLEAR_CMD && bytes_r == `SFRS_CMD_BYTES;
    wire upd_ev = whole && cmd_r == STATUS_UPDATE_CMD && bytes_r == `SFRS_STSW_BYTES &&
                  write_ok && !hw_lock;
    wire page_ev = whole && cmd_r == PAGE_WRITE_CMD && bytes_r >= `SFRS_PROG_MIN_BYTES &&
                   write_ok && !in_prot;
    wire block_ev = whole && cmd_r == BLOCK64K_WIPE_CMD && bytes_r == `SFRS_HDR_BYTES &&
                    write_ok && !in_prot;
    wire wipe_ev = whole && cmd_r == ARRAY_WIPE_CMD && bytes_r == `SFRS_CMD_BYTES &&
                   write_ok && prot_r == 3'h0;                                   // see RQ21
    wire sfrs_op_e kind_nxt = page_ev ? SFRS_OP_PAGE : (block_ev ? SFRS_OP_BLOCK : SFRS_OP_ARRAY);

    // Set wins over any clear arriving in the same cycle
    always_comb begin
        latch_nxt = latch_r;
        if (set_ev) begin
            latch_nxt = 1'b1;                                      // see RQ10
        end else if (clr_ev || upd_ev || op_done) begin
            latch_nxt = 1'b0;                                      // see RQ12, RQ13
        end
    end

    // Latch, protect field and lock bit
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tg_seen_r <= 1'b0;
            latch_r <= 1'b0;                                       // see RQ13
            prot_r <= `SFRS_PROT_RESET;
            lock_r <= `SFRS_LOCK_RESET;
        end else begin
            tg_seen_r <= frame_end ? tg_s_r : tg_seen_r;
            latch_r <= latch_nxt;
            if (upd_ev) begin
                // Latch bit of the written byte is ignored
                prot_r <= wdat_r[`SFRS_STS_PROT_MSB:`SFRS_STS_PROT_LSB];  // see RQ19
                lock_r <= wdat_r[`SFRS_STS_LOCK];
            end
        end
    end

    // Operation hand-off and visible status word
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            op_start_r <= 1'b0;
            op_kind_r <= SFRS_OP_PAGE;
            op_addr_r <= '0;
            status_word_r <= 8'h00;
        end else begin
            op_start_r <= page_ev || block_ev || wipe_ev;
            op_kind_r <= kind_nxt;
            op_addr_r <= addr_r[ADDR_W-1:0];
            status_word_r <= {lock_r, 2'b00, prot_r, latch_r, op_busy};  // see RQ17, RQ23
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_latch_set;
        @(posedge clk_sys) disable iff (!nrst)
        set_ev |=> latch_r ##1 status_word_r[`SFRS_STS_LATCH];
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch not set by set command"); // see RQ10

    property p_latch_clear;
        @(posedge clk_sys) disable iff (!nrst)
        (clr_ev || upd_ev || op_done) && !set_ev |=> !latch_r;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared"); // see RQ12

    property p_latch_hold;
        @(posedge clk_sys) disable iff (!nrst)
        !set_ev && !clr_ev && !upd_ev && !op_done |=> latch_r == $past(latch_r);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed with no cause"); // see RQ19

    property p_start_needs_latch;
        @(posedge clk_sys) disable iff (!nrst)
        op_start_r |-> $past(latch_r) && !$past(op_busy);
    endproperty
    a_start_needs_latch: assert property (p_start_needs_latch) else $error("operation started without latch"); // see RQ18

    property p_wipe_needs_clear_prot;
        @(posedge clk_sys) disable iff (!nrst)
        op_start_r && op_kind_r == SFRS_OP_ARRAY |-> $past(prot_r) == 3'h0;
    endproperty
    a_wipe_needs_clear_prot: assert property (p_wipe_needs_clear_prot) else $error("array wipe while protected"); // see RQ21

    property p_lock_freezes;
        @(posedge clk_sys) disable iff (!nrst)
        hw_lock |=> $stable(prot_r) && $stable(lock_r);
    endproperty
    a_lock_freezes: assert property (p_lock_freezes) else $error("status changed under hardware lock"); // see RQ22

    property p_busy_bit;
        @(posedge clk_sys) disable iff (!nrst)
        ##1 status_word_r[`SFRS_STS_BUSY] == $past(op_busy) && status_word_r[6:5] == 2'b00;
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit or unused bits wrong"); // see RQ17

    property p_addr_step;
        @(posedge sck) disable iff (!nrst || cs_n)
        tx_mode_r == SFRS_TX_ARRAY && !frame_fresh_r && byte_end |=>
            arr_addr_r == ADDR_W'($past(arr_addr_r) + 1'b1);
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("array address did not advance"); // see RQ4

    property p_reject_busy;
        @(posedge sck) disable iff (!nrst || cs_n)
        byte_end && sck_busy && mode_cur == SFRS_TX_NONE |=> tx_mode_r != SFRS_TX_ARRAY && tx_mode_r != SFRS_TX_ID;
    endproperty
    a_reject_busy: assert property (p_reject_busy) else $error("read accepted while busy"); // see RQ7

    property p_release;
        @(posedge clk_sys) disable iff (!nrst)
        cs_s_r && cs_d_r |-> so_oe_n_r;
    endproperty
    a_release: assert property (p_release) else $error("output driven with chip select high"); // see RQ6

endmodule

// [test/sfrs_host_model.sv]
// Behavioural host serial controller that frames commands for the flash front end
module sfrs_host_model (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so_r,
    input wire logic so_oe_n_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$]; // Bytes captured in the data phase
    bit oe_seen; // Output was driven at some data bit
    // Idle bus: deselected, clock parked low
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    ////////////////////////////////////////
    // One frame: header out, n_rx bytes in, x stray bits; clock runs only inside the frame
    // Frame length is a multiple of 8 ns so edges keep their offset from the system clock
    task automatic frame(input logic [7:0] tx[$], input int n_rx, input int x);
        logic [7:0] b;
        int nb;
        nb = tx.size() * 8;
        rx_q.delete();
        oe_seen = 1'b0;
        b = 8'h00;
        #3 cs_n = 1'b0;
        #80;
        for (int i = 0; i < nb + n_rx * 8 + x; i++) begin
            si = (i < nb) ? tx[i / 8][7 - i % 8] : ~si; // Msb first
            #80 sck = 1'b1; // 160 ns period, far under both ceilings
            if (i >= nb) begin
                b = {b[6:0], so_oe_n_r ? ~so_r : so_r}; // Released line reads as the inverse
                oe_seen |= !so_oe_n_r;
                if ((i - nb) % 8 == 7) rx_q.push_back(b);
            end
            #80 sck = 1'b0;
        end
        #80 cs_n = 1'b1; // Whole bytes unless x is set
        si = ~si; // Released line must not keep its last value
        #197;
    endtask
endmodule

// [test/test_serial_flash_read_status_front.sv]
// Self-checking bench for the serial flash command front end
module test_serial_flash_read_status_front;
    import sfrs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // Command codes, equal to the design defaults
    localparam logic [7:0] RD = 8'h03, FRD = 8'h0b, IDQ = 8'h9f, LSET = 8'h06, LCLR = 8'h04;
    localparam logic [7:0] STQ = 8'h05, STU = 8'h01, PGW = 8'h02, BLW = 8'hd8, ARW = 8'hc7;
    localparam logic [7:0] ID0 = 8'h71, ID1 = 8'h4e, ID2 = 8'h33; // Arbitrary identity values
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic write_protect_n = 1'b1;
    logic op_busy = 1'b0;
    logic op_done = 1'b0;
    wire sck, cs_n, si, so_r, so_oe_n_r, op_start_r;
    wire [21:0] arr_addr_r, op_addr_r;
    wire [7:0] status_word_r;
    sfrs_op_e op_kind_r, k_seen;
    logic [21:0] a_seen;
    logic [23:0] r;
    int miscompares = 0;
    int n_tests = 0;
    int eng_cnt = 0;
    int n_start = 0;
    bit m_latch, m_lock; // Model of the status fields
    logic [2:0] m_prot = 3'h0;
    ////////////////////////////////////////
    // Array content seen through the read port
    function automatic logic [7:0] mem_f(logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]} ^ 8'ha5;
    endfunction
    // Expected status byte
    function automatic logic [7:0] sts_f();
        return {m_lock, 2'h0, m_prot, m_latch, op_busy};
    endfunction
    // Block index falls in the shielded top range
    function automatic bit hit(logic [21:0] a);
        return m_prot == 3'h7 || (m_prot != 3'h0 && 32'(a[21:16]) >= 64 - (1 << (m_prot - 3'h1)));
    endfunction
    wire [7:0] arr_data = mem_f(arr_addr_r);
    always #4 clk_sys = ~clk_sys;
    sfrs_front #(.MAKER_CODE(ID0), .MEM_TYPE_CODE(ID1), .CAPACITY_CODE(ID2)) dut (.clk_sys(clk_sys),
        .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si), .so_r(so_r), .so_oe_n_r(so_oe_n_r),
        .write_protect_n(write_protect_n), .arr_addr_r(arr_addr_r), .arr_data(arr_data), .op_busy(op_busy),
        .op_done(op_done), .op_start_r(op_start_r), .op_kind_r(op_kind_r), .op_addr_r(op_addr_r),
        .status_word_r(status_word_r));
    sfrs_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so_r(so_r), .so_oe_n_r(so_oe_n_r));
    ////////////////////////////////////////
    // Engine stand-in: long busy after each start, then a done pulse
    always @(negedge clk_sys) begin
        op_done <= (eng_cnt == 1); // One-cycle pulse as the count runs out
        if (eng_cnt > 0) begin
            eng_cnt--;
            if (eng_cnt == 0) begin
                op_busy <= 1'b0;
                m_latch = 1'b0; // Completion drops the latch
            end
        end else if (op_start_r === 1'b1) begin
            op_busy <= 1'b1;
            eng_cnt = 4000;
            n_start++;
            k_seen = op_kind_r;
            a_seen = op_addr_r;
        end
    end
    ////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic note(input string s);
        $display("test %s finished, %0d checks so far", s, n_tests);
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Write-type frame of n bytes; status data rides in a[23:16]
    task automatic do_wr(input logic [7:0] c, input logic [23:0] a, input int n, input int x);
        logic [7:0] tx[$];
        int s0;
        bit ok;
        tx = {c, a[23:16], a[15:8], a[7:0], 8'h3c};
        s0 = n_start;
        ok = m_latch && !op_busy && x == 0;
        host.frame(tx[0:n-1], 0, x);
        repeat (10) @(negedge clk_sys);
        if (x == 0 && c == LSET) m_latch = 1'b1;
        if (x == 0 && c == LCLR) m_latch = 1'b0;
        if (ok && c == STU && !(m_lock && !write_protect_n)) begin
            {m_lock, m_prot} = {a[23], a[20:18]};
            m_latch = 1'b0;
        end
        ok = ok && (c == PGW && !hit(a) || c == BLW && !hit(a) || c == ARW && m_prot == 3'h0);
        chk(n_start - s0, ok);
        if (ok) chk(k_seen, c == PGW ? SFRS_OP_PAGE : c == BLW ? SFRS_OP_BLOCK : SFRS_OP_ARRAY);
        if (ok && c != ARW) chk(a_seen, a[21:0]);
        chk(status_word_r, sts_f());
    endtask
    // Read-type frame, n bytes back
    task automatic rd(input logic [7:0] c, input logic [23:0] a, input int n);
        logic [7:0] tx[$];
        logic [7:0] e;
        bit busy;
        busy = op_busy;
        tx = {c, a[23:16], a[15:8], a[7:0], 8'h00};
        host.frame(tx[0:(c == RD ? 3 : c == FRD ? 4 : 0)], n, 0);
        chk(so_oe_n_r, 1'b1);
        chk(host.oe_seen, c == STQ || !busy);
        for (int i = 0; i < n && (c == STQ || !busy); i++) begin
            e = c == STQ ? sts_f() : c == IDQ ? (i % 3 == 0 ? ID0 : i % 3 == 1 ? ID1 : ID2) : mem_f(a[21:0] + i);
            chk(host.rx_q[i], e);
        end
    endtask
    // Host waits out a running operation by status queries
    task automatic poll();
        for (int i = 0; i < 40 && op_busy; i++) host.frame({STQ}, 1, 0);
        repeat (4) @(negedge clk_sys);
        chk(status_word_r, sts_f());
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(54475));
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        chk({so_oe_n_r, op_start_r, status_word_r}, 10'h200);
        repeat (5) @(posedge clk_sys);
        rd(STQ, 24'h0, 3);
        do_wr(LSET, 24'h0, 1, 0);
        do_wr(LCLR, 24'h0, 1, 0);
        do_wr(LSET, 24'h0, 1, 1);
        do_wr(LSET, 24'h0, 1, 0);
        do_wr(STU, 24'h670000, 2, 0);
        note("latch and status update");
        do_wr(LSET, 24'h0, 1, 0);
        do_wr(ARW, 24'h0, 1, 0);
        do_wr(BLW, 24'h3f0000, 4, 0);
        do_wr(BLW, 24'h3e1234, 4, 0);
        rd(RD, 24'h10, 2);
        rd(FRD, 24'h10, 2);
        rd(IDQ, 24'h0, 3);
        rd(STQ, 24'h0, 2);
        poll();
        r = 24'($urandom);
        do_wr(PGW, r, 5, 0);
        note("protection and busy");
        do_wr(LSET, 24'h0, 1, 0);
        do_wr(STU, r, 2, 0);
        do_wr(LSET, 24'h0, 1, 0);
        do_wr(STU, 24'h0, 2, 0);
        do_wr(LSET, 24'h0, 1, 0);
        do_wr(ARW, 24'h0, 1, 0);
        poll();
        do_wr(LSET, 24'h0, 1, 0);
        do_wr(PGW, r, 5, 0);
        poll();
        note("operations");
        rd(RD, 24'hfffffe, 4);
        rd(FRD, r, 3);
        rd(IDQ, 24'h0, 4);
        note("reads");
        do_wr(LSET, 24'h0, 1, 0);
        do_wr(STU, 24'h800000, 2, 0);
        @(negedge clk_sys) write_protect_n = 1'b0;
        do_wr(LSET, 24'h0, 1, 0);
        do_wr(STU, 24'h1c0000, 2, 0);
        @(negedge clk_sys) write_protect_n = 1'b1;
        do_wr(STU, 24'h0, 2, 0);
        rd(STQ, 24'h0, 2);
        note("hardware lock");
        summarize();
    end
    // Watchdog against a hang
    initial begin
        #600us;
        miscompares++;
        summarize();
    end
endmodule
